// ==== logic/uef_pkg.sv ====
package uef_pkg;
  // Number of endpoints served
  localparam int UEF_NUM_EP = 6;
  // Register offsets on the plain port
  localparam logic [7:0] UEF_FIFO_RST_OFS = 8'hd5; // endpoint_fifo_reset_ctrl
  localparam logic [7:0] UEF_SUMMARY_OFS = 8'hf8; // endpoint_irq_summary
  localparam logic [7:0] UEF_IRQ_EN_OFS = 8'hd6; // endpoint_irq_enable_reg
  localparam logic [7:0] UEF_IRQ_STAT_OFS = 8'hd7; // Sticky event status
  localparam logic [7:0] UEF_IRQ_MASK_OFS = 8'hd8; // Event mask
  // Reset values
  localparam logic [5:0] UEF_FIFO_RST_INIT = 6'h00;
  localparam logic [5:0] UEF_IRQ_EN_INIT = 6'h00;
  localparam logic [5:0] UEF_MASK_INIT = 6'h00;
  // Reserved upper bits of an 8-bit register
  localparam logic [1:0] UEF_RSVD_ZERO = 2'h0;
endpackage

// ==== logic/uef_src_flag.sv ====
// One endpoint's summary flag and its rising-edge event
module uef_src_flag
  import uef_pkg::*;
#(
  parameter int SRC_W = 5 // Status sources per endpoint
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [SRC_W-1:0] src,
  output logic pending,
  output logic rise
);
  // Registered summary flag
  typedef struct packed {
    logic pend;
  } uef_flag_s;
  uef_flag_s st_reg, st_next;

  // Flag follows OR of all sources, clears itself when all drop
  always_comb begin
    st_next = st_reg;
    st_next.pend = |src;
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pending = st_reg.pend;
  assign rise = st_next.pend & ~st_reg.pend;
endmodule // uef_src_flag

// ==== logic/uef_ctrl.sv ====
module uef_ctrl
  import uef_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [4:0] ep_src [UEF_NUM_EP],
  output logic [5:0] ep_fifo_flush,
  output logic usb_ep_irq,
  output logic irq
);
  // All register-file state in one struct; the summary flags are held in the flag instances
  typedef struct packed {
    logic [5:0] fifo_rst;
    logic [5:0] irq_en;
    logic [5:0] stat;
    logic [5:0] mask;
    logic [7:0] rdata;
  } uef_state_s;
  uef_state_s st_reg, st_next;

  logic [5:0] pend; // Summary flags per endpoint
  logic [5:0] rise; // New-pending events

  // Per-endpoint flag instances
  genvar g;
  generate
    for (g = 0; g < UEF_NUM_EP; g++) begin : g_ep
      uef_src_flag u_flag (
        .mclk(mclk),
        .reset_n(reset_n),
        .src(ep_src[g]),
        .pending(pend[g]),
        .rise(rise[g])
      );
    end
  endgenerate

  // Next-state logic for registers and read data
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    // Register writes
    if (wr_stb) begin
      unique case (addr)
        // Only low six bits stored; upper bits dropped
        UEF_FIFO_RST_OFS: st_next.fifo_rst = wdata[5:0];
        UEF_IRQ_EN_OFS: st_next.irq_en = wdata[5:0];
        UEF_IRQ_MASK_OFS: st_next.mask = wdata[5:0];
        default: ;
      endcase
    end
    // Reads, data one cycle later
    if (rd_stb) begin
      unique case (addr)
        UEF_FIFO_RST_OFS: st_next.rdata = {UEF_RSVD_ZERO, st_reg.fifo_rst};
        UEF_SUMMARY_OFS: st_next.rdata = {UEF_RSVD_ZERO, pend};
        UEF_IRQ_EN_OFS: st_next.rdata = {UEF_RSVD_ZERO, st_reg.irq_en};
        UEF_IRQ_STAT_OFS: st_next.rdata = {UEF_RSVD_ZERO, st_reg.stat};
        UEF_IRQ_MASK_OFS: st_next.rdata = {UEF_RSVD_ZERO, st_reg.mask};
        default: st_next.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
    // Sticky status: read clears, but a same-cycle event wins
    if (rd_stb && addr == UEF_IRQ_STAT_OFS) begin
      st_next.stat = rise;
    end else begin
      st_next.stat = st_reg.stat | rise;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{fifo_rst: UEF_FIFO_RST_INIT, irq_en: UEF_IRQ_EN_INIT,
                  stat: 6'h00, mask: UEF_MASK_INIT, rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // Each bit flushes only its own FIFO
  assign ep_fifo_flush = st_reg.fifo_rst;
  // USB interrupt gated per endpoint
  assign usb_ep_irq = |(pend & st_reg.irq_en);
  // Event interrupt level
  assign irq = |(st_reg.stat & st_reg.mask);
  assign rdata = st_reg.rdata;

  // Per-endpoint OR of the raw sources, feeds the checks below only
  logic [5:0] src_any;
  always_comb begin
    src_any = 6'h00;
    for (int i = 0; i < UEF_NUM_EP; i++) begin
      src_any[i] = |ep_src[i];
    end
  end

  // Written reset bits appear on flush outputs next cycle
  property p_flush_write;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && addr == UEF_FIFO_RST_OFS |=> ep_fifo_flush == $past(wdata[5:0]);
  endproperty
  a_flush_write: assert property (p_flush_write) else $error("flush bits not loaded");

  // Reserved bits of reset register read zero
  property p_rsvd_zero;
    @(posedge mclk) disable iff (!reset_n)
      rd_stb && addr == UEF_FIFO_RST_OFS |=> rdata[7:6] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  // Flush holds without a write to the register
  property p_flush_hold;
    @(posedge mclk) disable iff (!reset_n)
      !(wr_stb && addr == UEF_FIFO_RST_OFS) |=> $stable(ep_fifo_flush);
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush changed unasked");

  // Summary read returns flags
  sequence s_sum_rd;
    rd_stb && addr == UEF_SUMMARY_OFS;
  endsequence
  property p_summary;
    @(posedge mclk) disable iff (!reset_n)
      s_sum_rd |=> rdata == {2'h0, $past(pend)};
  endproperty
  a_summary: assert property (p_summary) else $error("summary read wrong");

  // Flag follows sources one cycle later
  property p_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> pend[0] == |$past(ep_src[0]);
  endproperty
  a_flag: assert property (p_flag) else $error("ep0 flag wrong");

  // Written enable bits decide which flags may raise the USB interrupt
  property p_gate;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && addr == UEF_IRQ_EN_OFS |=> usb_ep_irq == |(pend & $past(wdata[5:0]));
  endproperty
  a_gate: assert property (p_gate) else $error("usb irq not gated");

  // Reset register read back equals last write
  property p_readback;
    @(posedge mclk) disable iff (!reset_n)
      rd_stb && addr == UEF_FIFO_RST_OFS |=> rdata[5:0] == ep_fifo_flush;
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  // Register file keeps flushes when enable written
  property p_indep;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && addr == UEF_IRQ_EN_OFS |=> $stable(ep_fifo_flush);
  endproperty
  a_indep: assert property (p_indep) else $error("flush disturbed");

  // Every summary flag tracks its own sources a cycle later
  property p_flag_all;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> pend == $past(src_any);
  endproperty
  a_flag_all: assert property (p_flag_all) else $error("summary flags wrong");

  // Upper bits read zero whatever place is read
  property p_rsvd_all;
    @(posedge mclk) disable iff (!reset_n)
      rd_stb |=> rdata[7:6] == 2'h0;
  endproperty
  a_rsvd_all: assert property (p_rsvd_all) else $error("upper read bits nonzero");

  // A write aimed at the summary place changes neither the flush nor the enable register
  property p_sum_ro;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && addr == UEF_SUMMARY_OFS |=> $stable(ep_fifo_flush) && $stable(st_reg.irq_en);
  endproperty
  a_sum_ro: assert property (p_sum_ro) else $error("summary place took a write");

  // Write, one quiet cycle, then read back of the reset register
  sequence s_rst_wr;
    wr_stb && addr == UEF_FIFO_RST_OFS;
  endsequence
  sequence s_rst_rd;
    rd_stb && addr == UEF_FIFO_RST_OFS;
  endsequence
  property p_wr_rd;
    @(posedge mclk) disable iff (!reset_n)
      s_rst_wr ##1 !wr_stb ##1 s_rst_rd |=> rdata[5:0] == $past(wdata[5:0], 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("reset bits not read back");

  // A new event lands in status, even in its clearing read cycle
  property p_stat_set;
    @(posedge mclk) disable iff (!reset_n)
      rise != 6'h00 |=> (st_reg.stat & $past(rise)) == $past(rise);
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("event lost from status");

  // Clearing read with no new event empties status
  property p_stat_clr;
    @(posedge mclk) disable iff (!reset_n)
      rd_stb && addr == UEF_IRQ_STAT_OFS && rise == 6'h00 |=> st_reg.stat == 6'h00;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read");

  // Mask write decides the event interrupt level
  property p_mask;
    @(posedge mclk) disable iff (!reset_n)
      wr_stb && addr == UEF_IRQ_MASK_OFS |=> irq == |(st_reg.stat & $past(wdata[5:0]));
  endproperty
  a_mask: assert property (p_mask) else $error("event irq not masked");
endmodule // uef_ctrl

// ==== sim/tb_top.sv ====
module tb_top
  import uef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, wr_stb, rd_stb, usb_ep_irq, irq, rd_p;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] ep_src [UEF_NUM_EP];
  logic [5:0] ep_fifo_flush, v, pend, en;
  logic [7:0] exp_q [$]; // Expected read data, oldest first
  int n_errors = 0, checks_done = 0, cyc = 0, seed = 51;
  uef_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .ep_src(ep_src), .ep_fifo_flush(ep_fifo_flush),
    .usb_ep_irq(usb_ep_irq), .irq(irq));
  // Free running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compare one value, count it
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One cycle strobes, master never waits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) rd_p <= rd_stb;
  always @(negedge mclk) if (rd_p) chk("rdata", exp_q.pop_front(), rdata);
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the sequence length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    reset_n = 1'b0;
    {addr, wdata, wr_stb, rd_stb} = '0;
    for (int i = 0; i < UEF_NUM_EP; i++) ep_src[i] = 5'h00;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rd(UEF_FIFO_RST_OFS, 8'h00);
    wr(UEF_FIFO_RST_OFS, 8'h3f);
    @(negedge mclk);
    chk("flush", 8'h3f, {2'h0, ep_fifo_flush});
    rd(UEF_SUMMARY_OFS, 8'h00);
    $display("test 1 finished");
    // Random flush patterns, reserved bits kept clear
    repeat (4) begin
      v = 6'($random(seed));
      wr(UEF_FIFO_RST_OFS, {2'h0, v});
      @(negedge mclk);
      chk("flush", {2'h0, v}, {2'h0, ep_fifo_flush});
      rd(UEF_FIFO_RST_OFS, {2'h0, v});
    end
    rd(8'h9a, 8'h00); // Unmapped place reads zero
    wr(UEF_FIFO_RST_OFS, 8'h00);
    @(negedge mclk);
    chk("flush", 8'h00, {2'h0, ep_fifo_flush});
    $display("test 2 finished");
    @(posedge mclk);
    // Endpoint sources, any one raises the flag
    for (int i = 0; i < UEF_NUM_EP; i++) begin
      ep_src[i] <= (i == 0) ? 5'h01 : 5'($random(seed));
    end
    @(posedge mclk);
    for (int i = 0; i < UEF_NUM_EP; i++) pend[i] = |ep_src[i];
    repeat (3) @(posedge mclk);
    rd(UEF_SUMMARY_OFS, {2'h0, pend});
    wr(UEF_SUMMARY_OFS, 8'hff);
    rd(UEF_SUMMARY_OFS, {2'h0, pend});
    $display("test 3 finished");
    en = 6'($random(seed));
    wr(UEF_IRQ_EN_OFS, {2'h0, en});
    @(negedge mclk);
    chk("usb_irq", {7'h0, |(pend & en)}, {7'h0, usb_ep_irq});
    wr(UEF_IRQ_EN_OFS, 8'h3f);
    @(negedge mclk);
    chk("usb_irq", 8'h01, {7'h0, usb_ep_irq});
    $display("test 4 finished");
    // Sticky status, masked then cleared by reading
    @(negedge mclk);
    chk("irq", 8'h00, {7'h0, irq});
    wr(UEF_IRQ_MASK_OFS, 8'h3f);
    @(negedge mclk);
    chk("irq", 8'h01, {7'h0, irq});
    rd(UEF_IRQ_STAT_OFS, {2'h0, pend});
    repeat (2) @(negedge mclk);
    chk("irq", 8'h00, {7'h0, irq});
    @(posedge mclk);
    for (int i = 0; i < UEF_NUM_EP; i++) ep_src[i] <= 5'h00;
    repeat (3) @(posedge mclk);
    rd(UEF_SUMMARY_OFS, 8'h00);
    // Event in the clearing read's own cycle must survive it
    fork
      rd(UEF_IRQ_STAT_OFS, 8'h00);
      begin
        @(posedge mclk);
        ep_src[1] <= 5'h02;
      end
    join
    @(negedge mclk);
    chk("irq", 8'h01, {7'h0, irq});
    rd(UEF_IRQ_STAT_OFS, 8'h02);
    $display("test 5 finished");
    repeat (3) @(posedge mclk);
    final_report();
  end
endmodule // tb_top
